/* File: ebw_partner.sv */
// External memory model answering with the ready handshake
`timescale 1ns/1ps
module ebw_partner (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [7:0] delay_i,
	input wire logic pol_i,
	input wire logic [15:0] rdval_i,
	output logic ready_o,
	output logic [15:0] data_o
);
	logic [7:0] cnt_q;
	logic st_q, done_q, rdy_q, strb, drop;
	assign strb = !(rd_n_i && wr_n_i);
	assign drop = done_q || (st_q && !strb);
	// Active level per polarity
	assign ready_o = pol_i ? rdy_q : !rdy_q;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= 8'h00;
			st_q <= 1'b0;
			done_q <= 1'b0;
			rdy_q <= 1'b0;
			data_o <= 16'h0000;
		end else begin
			cnt_q <= cs_n_i ? 8'h00 : cnt_q + {7'h0, cnt_q != 8'hFF};
			st_q <= strb;
			done_q <= !cs_n_i && drop;
			// Late answer, held until strobe rises, off before next cycle
			rdy_q <= !cs_n_i && !drop && cnt_q >= delay_i;
			// Data only while selected, scrambled after strobe rises
			data_o <= (!cs_n_i && !drop && wr_n_i) ? rdval_i : ~data_o;
		end
	end
endmodule

/* File: ebw_pkg.sv */
// Constants, field layout and state encoding of the bus ready/wait control
// What this block does
// - External module stretches a bus cycle through the ready input; device obeys it.
// - Ready input polarity is selectable and the sampled level is read by it.
// - Synchronous ready mode samples the two-flop synchronised input; partner drives it synchronous to reference clock.
// - Asynchronous ready mode adds a synchroniser stage and always at least one wait state.
// - First ready sample point follows the cycle's programmed phase lengths.
// - Ready sampled inactive inserts one ready wait state, then samples again.
// - Ready sampled active ends the access phase of the running bus cycle.
// - Asynchronous sample point lies one stage later than the synchronous one.
// - Read data captured on the edge that raises read strobe; address holds until the next cycle.
// - Address change before read strobe ends never alters captured read data.
// - Each cycle runs address setup, command delay, data setup, access, hold phases.
// - Phase lengths: setup 1-2 plus 0-3 on window change, 0-3, 0-1, 1-32, 0-3.
// - Ready only extends access phase, after its programmed mandatory length elapses.
package ebw_pkg;
	localparam int AXI_AW = 8;
	localparam int EXT_AW = 24;
	localparam int EXT_DW = 16;
	localparam int WIN_LSB = 16;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PHASE = 8'h04;
	localparam logic [7:0] OFS_ADDR = 8'h08;
	localparam logic [7:0] OFS_WDATA = 8'h0C;
	localparam logic [7:0] OFS_CMD = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [7:0] OFS_RDATA = 8'h18;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_POL_BIT = 1;
	localparam int CTRL_ASYNC_BIT = 2;
	localparam logic [31:0] CTRL_RST = 32'h0000_0002;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0007;
	localparam int PH_AB_BIT = 0;
	localparam int PH_EXT_LSB = 2;
	localparam int PH_C_LSB = 4;
	localparam int PH_D_BIT = 6;
	localparam int PH_E_LSB = 8;
	localparam int PH_F_LSB = 16;
	localparam logic [31:0] PHASE_RST = 32'h0000_0000;
	localparam logic [31:0] PHASE_MASK = 32'h0003_1F7D;
	localparam logic [31:0] ADDR_MASK = 32'h00FF_FFFF;
	localparam logic [31:0] WDATA_MASK = 32'h0000_FFFF;
	localparam int CMD_GO_BIT = 0;
	localparam int CMD_WR_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_WAIT_LSB = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// Bus cycle states, Gray along the path
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_AB = 3'h1,
		ST_C = 3'h3,
		ST_D = 3'h2,
		ST_E = 3'h6,
		ST_RDY = 3'h7,
		ST_F = 3'h5
	} ebw_state_e;
endpackage

/* File: ebw_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ebw_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_q <= '0;
			q_o <= '0;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule

/* File: ebw_tick_div.sv */
// Divider for the phase time unit and the bus reference clock
`timescale 1ns/1ps
module ebw_tick_div #(
	parameter int DIV = 2
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	ebw_tick_if.src tk
);
	localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] HALF = CW'(DIV / 2);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
		$error("DIV must be even and at least 2");
	end
	always_comb begin
		cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
	end
	// Reference clock high in first half; tick on the last count
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= '0;
			tk.tick <= 1'b0;
			tk.ref_clk <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tk.tick <= (cnt_d == LAST);
			tk.ref_clk <= (cnt_d < HALF);
		end
	end
endmodule

/* File: ebw_tick_if.sv */
// Phase time unit tick and reference clock carrier
`timescale 1ns/1ps
interface ebw_tick_if;
	logic tick;
	logic ref_clk;
	modport src (output tick, output ref_clk);
	modport dst (input tick, input ref_clk);
endinterface

/* File: ebw_top.sv */
// External bus cycle engine with ready wait control and AXI4-Lite registers
`timescale 1ns/1ps
module ebw_top #(
	parameter int TCS_DIV = 2
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic bus_reference_clock_o,
	output logic cs_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic [23:0] addr_o,
	output logic [15:0] data_o,
	output logic data_oe_o,
	input wire logic [15:0] data_i,
	input wire logic ready_i
);
	// ----------------------------------------
	// Clocking and pin synchronisers
	// ----------------------------------------
	ebw_tick_if tk ();
	logic rdy_s;
	logic [15:0] data_s;

	ebw_tick_div #(.DIV(TCS_DIV)) u_div (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.tk(tk.src)
	);
	ebw_sync #(.W(1)) u_rdy_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i(ready_i),
		.q_o(rdy_s)
	);
	ebw_sync #(.W(16)) u_dat_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i(data_i),
		.q_o(data_s)
	);
	assign bus_reference_clock_o = tk.ref_clk;

	// ----------------------------------------
	// Register bus state
	// ----------------------------------------
	logic aw_rdy_q, aw_rdy_d, aw_full_q, aw_full_d;
	logic w_rdy_q, w_rdy_d, w_full_q, w_full_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic ar_rdy_q, ar_rdy_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] ctrl_q, ctrl_d, phase_q, phase_d;
	logic [31:0] addr_reg_q, addr_reg_d, wdat_reg_q, wdat_reg_d;
	logic go_q, go_d, go_wr_q, go_wr_d;

	// ----------------------------------------
	// Bus cycle state
	// ----------------------------------------
	ebw_pkg::ebw_state_e st_q, st_d, nx;
	logic [4:0] cnt_q, cnt_d, last;
	logic [1:0] ext_q, ext_d;
	logic [7:0] win_q, win_d;
	logic [7:0] wait_q, wait_d;
	logic [15:0] rdat_q, rdat_d;
	logic rdy_dly_q, rdy_dly_d;
	logic cs_n_q, cs_n_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d, oe_q, oe_d;
	logic is_wr_q, is_wr_d;
	logic [23:0] addr_q, addr_d;
	logic [15:0] dout_q, dout_d;
	logic take, busy, rdy_lvl, rdy_ok, async_m, rdy_en;
	logic [1:0] c_len, f_len;

	assign busy = (st_q != ebw_pkg::ST_IDLE) || go_q;
	assign async_m = ctrl_q[ebw_pkg::CTRL_ASYNC_BIT];
	assign rdy_en = ctrl_q[ebw_pkg::CTRL_EN_BIT];
	assign c_len = phase_q[ebw_pkg::PH_C_LSB +: 2];
	assign f_len = phase_q[ebw_pkg::PH_F_LSB +: 2];
	// Level after polarity selection
	assign rdy_lvl = ctrl_q[ebw_pkg::CTRL_POL_BIT] ? rdy_s : ~rdy_s;
	// Async path reads value one tick older
	assign rdy_ok = !rdy_en || (async_m ? rdy_dly_q : rdy_lvl);

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	// ----------------------------------------
	// AXI4-Lite slave and registers
	// ----------------------------------------
	always_comb begin
		aw_rdy_d = aw_rdy_q;
		aw_full_d = aw_full_q;
		awaddr_d = awaddr_q;
		w_rdy_d = w_rdy_q;
		w_full_d = w_full_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		ar_rdy_d = ar_rdy_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		ctrl_d = ctrl_q;
		phase_d = phase_q;
		addr_reg_d = addr_reg_q;
		wdat_reg_d = wdat_reg_q;
		go_d = go_q && !take;
		go_wr_d = go_wr_q;
		if (s_axi_awvalid_i && aw_rdy_q) begin
			aw_rdy_d = 1'b0;
			aw_full_d = 1'b1;
			awaddr_d = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && w_rdy_q) begin
			w_rdy_d = 1'b0;
			w_full_d = 1'b1;
			wdata_d = s_axi_wdata_i;
			wstrb_d = s_axi_wstrb_i;
		end
		if (aw_full_q && w_full_q && !bvalid_q) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = ebw_pkg::RESP_OKAY;
			if (awaddr_q == ebw_pkg::OFS_CTRL) begin
				ctrl_d = merge(ctrl_q, wdata_q, wstrb_q) & ebw_pkg::CTRL_MASK;
			end else if (awaddr_q == ebw_pkg::OFS_PHASE) begin
				phase_d = merge(phase_q, wdata_q, wstrb_q) & ebw_pkg::PHASE_MASK;
			end else if (awaddr_q == ebw_pkg::OFS_ADDR) begin
				addr_reg_d = merge(addr_reg_q, wdata_q, wstrb_q) & ebw_pkg::ADDR_MASK;
			end else if (awaddr_q == ebw_pkg::OFS_WDATA) begin
				wdat_reg_d = merge(wdat_reg_q, wdata_q, wstrb_q) & ebw_pkg::WDATA_MASK;
			end else if (awaddr_q == ebw_pkg::OFS_CMD) begin
				if (busy) begin
					bresp_d = ebw_pkg::RESP_SLVERR;
				end else if (wstrb_q[0] && wdata_q[ebw_pkg::CMD_GO_BIT]) begin
					go_d = 1'b1;
					go_wr_d = wdata_q[ebw_pkg::CMD_WR_BIT];
				end
			end else if (awaddr_q == ebw_pkg::OFS_STAT || awaddr_q == ebw_pkg::OFS_RDATA) begin
				bresp_d = ebw_pkg::RESP_OKAY;
			end else begin
				bresp_d = ebw_pkg::RESP_SLVERR;
			end
		end
		if (bvalid_q && s_axi_bready_i) begin
			bvalid_d = 1'b0;
			aw_rdy_d = 1'b1;
			w_rdy_d = 1'b1;
		end
		if (s_axi_arvalid_i && ar_rdy_q) begin
			ar_rdy_d = 1'b0;
			rvalid_d = 1'b1;
			rresp_d = ebw_pkg::RESP_OKAY;
			rdata_d = 32'h0000_0000;
			if (s_axi_araddr_i == ebw_pkg::OFS_CTRL) begin
				rdata_d = ctrl_q;
			end else if (s_axi_araddr_i == ebw_pkg::OFS_PHASE) begin
				rdata_d = phase_q;
			end else if (s_axi_araddr_i == ebw_pkg::OFS_ADDR) begin
				rdata_d = addr_reg_q;
			end else if (s_axi_araddr_i == ebw_pkg::OFS_WDATA) begin
				rdata_d = wdat_reg_q;
			end else if (s_axi_araddr_i == ebw_pkg::OFS_CMD) begin
				rdata_d = 32'h0000_0000;
			end else if (s_axi_araddr_i == ebw_pkg::OFS_STAT) begin
				rdata_d[ebw_pkg::STAT_BUSY_BIT] = busy;
				rdata_d[ebw_pkg::STAT_WAIT_LSB +: 8] = wait_q;
			end else if (s_axi_araddr_i == ebw_pkg::OFS_RDATA) begin
				rdata_d = {16'h0000, rdat_q};
			end else begin
				rresp_d = ebw_pkg::RESP_SLVERR;
			end
		end
		if (rvalid_q && s_axi_rready_i) begin
			rvalid_d = 1'b0;
			ar_rdy_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_rdy_q <= 1'b1;
			aw_full_q <= 1'b0;
			awaddr_q <= 8'h00;
			w_rdy_q <= 1'b1;
			w_full_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= ebw_pkg::RESP_OKAY;
			ar_rdy_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= ebw_pkg::RESP_OKAY;
			ctrl_q <= ebw_pkg::CTRL_RST;
			phase_q <= ebw_pkg::PHASE_RST;
			addr_reg_q <= 32'h0000_0000;
			wdat_reg_q <= 32'h0000_0000;
			go_q <= 1'b0;
			go_wr_q <= 1'b0;
		end else begin
			aw_rdy_q <= aw_rdy_d;
			aw_full_q <= aw_full_d;
			awaddr_q <= awaddr_d;
			w_rdy_q <= w_rdy_d;
			w_full_q <= w_full_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			ar_rdy_q <= ar_rdy_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			ctrl_q <= ctrl_d;
			phase_q <= phase_d;
			addr_reg_q <= addr_reg_d;
			wdat_reg_q <= wdat_reg_d;
			go_q <= go_d;
			go_wr_q <= go_wr_d;
		end
	end

	// ----------------------------------------
	// Bus cycle phase sequencer
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		ext_d = ext_q;
		win_d = win_q;
		wait_d = wait_q;
		rdat_d = rdat_q;
		rdy_dly_d = rdy_dly_q;
		cs_n_d = cs_n_q;
		rd_n_d = rd_n_q;
		wr_n_d = wr_n_q;
		oe_d = oe_q;
		is_wr_d = is_wr_q;
		addr_d = addr_q;
		dout_d = dout_q;
		take = 1'b0;
		nx = ebw_pkg::ST_IDLE;
		// Last count of the current phase, in phase time units
		case (st_q)
			ebw_pkg::ST_AB: last = {4'h0, phase_q[ebw_pkg::PH_AB_BIT]}
				+ {3'h0, ext_q};
			ebw_pkg::ST_C: last = {3'h0, c_len} - 5'h01;
			ebw_pkg::ST_E: last = phase_q[ebw_pkg::PH_E_LSB +: 5];
			ebw_pkg::ST_F: last = {3'h0, f_len} - 5'h01;
			default: last = 5'h00;
		endcase
		// Zero length phases are skipped
		case (st_q)
			ebw_pkg::ST_AB: nx = (c_len != 2'h0) ? ebw_pkg::ST_C :
				phase_q[ebw_pkg::PH_D_BIT] ? ebw_pkg::ST_D : ebw_pkg::ST_E;
			ebw_pkg::ST_C: nx = phase_q[ebw_pkg::PH_D_BIT] ?
				ebw_pkg::ST_D : ebw_pkg::ST_E;
			default: nx = ebw_pkg::ST_E;
		endcase
		if (tk.tick) begin
			rdy_dly_d = rdy_lvl;
			case (st_q)
				ebw_pkg::ST_IDLE: begin
					if (go_q) begin
						take = 1'b1;
						st_d = ebw_pkg::ST_AB;
						cnt_d = 5'h00;
						cs_n_d = 1'b0;
						is_wr_d = go_wr_q;
						oe_d = go_wr_q;
						addr_d = addr_reg_q[23:0];
						dout_d = wdat_reg_q[15:0];
						wait_d = 8'h00;
						win_d = addr_reg_q[ebw_pkg::WIN_LSB +: 8];
						ext_d = (addr_reg_q[ebw_pkg::WIN_LSB +: 8] != win_q) ?
							phase_q[ebw_pkg::PH_EXT_LSB +: 2] : 2'h0;
					end
				end
				ebw_pkg::ST_AB, ebw_pkg::ST_C, ebw_pkg::ST_D: begin
					if (cnt_q == last) begin
						cnt_d = 5'h00;
						st_d = nx;
						if (nx == ebw_pkg::ST_E) begin
							rd_n_d = is_wr_q;
							wr_n_d = !is_wr_q;
						end
					end else begin
						cnt_d = cnt_q + 5'h01;
					end
				end
				ebw_pkg::ST_E, ebw_pkg::ST_RDY: begin
					if (cnt_q != last) begin
						cnt_d = cnt_q + 5'h01;
					end else if (!rdy_ok || (rdy_en && async_m &&
						st_q == ebw_pkg::ST_E)) begin
						// Sample point found not ready: wait one unit
						st_d = ebw_pkg::ST_RDY;
						cnt_d = 5'h00;
						if (wait_q != 8'hFF)
							wait_d = wait_q + 8'h01;
					end else begin
						// Strobe rises and data are caught on one edge
						cnt_d = 5'h00;
						rd_n_d = 1'b1;
						wr_n_d = 1'b1;
						if (!is_wr_q)
							rdat_d = data_s;
						if (f_len != 2'h0) begin
							st_d = ebw_pkg::ST_F;
						end else begin
							st_d = ebw_pkg::ST_IDLE;
							cs_n_d = 1'b1;
							oe_d = 1'b0;
						end
					end
				end
				default: begin
					if (cnt_q == last) begin
						cnt_d = 5'h00;
						st_d = ebw_pkg::ST_IDLE;
						cs_n_d = 1'b1;
						oe_d = 1'b0;
					end else begin
						cnt_d = cnt_q + 5'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= ebw_pkg::ST_IDLE;
			cnt_q <= 5'h00;
			ext_q <= 2'h0;
			win_q <= 8'h00;
			wait_q <= 8'h00;
			rdat_q <= 16'h0000;
			rdy_dly_q <= 1'b0;
			cs_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			oe_q <= 1'b0;
			is_wr_q <= 1'b0;
			addr_q <= 24'h00_0000;
			dout_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			ext_q <= ext_d;
			win_q <= win_d;
			wait_q <= wait_d;
			rdat_q <= rdat_d;
			rdy_dly_q <= rdy_dly_d;
			cs_n_q <= cs_n_d;
			rd_n_q <= rd_n_d;
			wr_n_q <= wr_n_d;
			oe_q <= oe_d;
			is_wr_q <= is_wr_d;
			addr_q <= addr_d;
			dout_q <= dout_d;
		end
	end

	assign s_axi_awready_o = aw_rdy_q;
	assign s_axi_wready_o = w_rdy_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_arready_o = ar_rdy_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;
	assign cs_n_o = cs_n_q;
	assign rd_n_o = rd_n_q;
	assign wr_n_o = wr_n_q;
	assign data_oe_o = oe_q;
	assign addr_o = addr_q;
	assign data_o = dout_q;
endmodule

/* File: ebw_top_monitor.sv */
// Pin timing checker for the ready/wait bus engine
`timescale 1ns/1ps
module ebw_top_monitor #(
	parameter int TCS_DIV = 2
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic bus_reference_clock_o,
	input wire logic cs_n_o,
	input wire logic rd_n_o,
	input wire logic wr_n_o,
	input wire logic [23:0] addr_o,
	input wire logic data_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	a_rd_in_cs: assert property (!rd_n_o |-> !cs_n_o)
		else $error("read strobe outside select");
	a_wr_in_cs: assert property (!wr_n_o |-> !cs_n_o)
		else $error("write strobe outside select");
	a_oe_no_read: assert property (data_oe_o |-> !cs_n_o && rd_n_o)
		else $error("data driven outside write");
	a_addr_held: assert property (!cs_n_o && !$past(cs_n_o) |-> $stable(addr_o))
		else $error("address moved in cycle");
	a_pins_on_unit: assert property (($changed(cs_n_o) || $changed(rd_n_o)
		|| $changed(wr_n_o)) |-> $rose(bus_reference_clock_o))
		else $error("pin change off unit boundary");
	a_access_min: assert property ($fell(rd_n_o) |=> !rd_n_o)
		else $error("access shorter than one unit");
	a_setup_first: assert property (($fell(rd_n_o) || $fell(wr_n_o))
		|-> !$past(cs_n_o))
		else $error("strobe without address setup");
	a_ref_runs: assert property (!bus_reference_clock_o
		|-> ##[1:16] bus_reference_clock_o)
		else $error("reference clock stuck");
endmodule
bind ebw_top ebw_top_monitor #(.TCS_DIV(TCS_DIV)) u_mon (
	.clk_i(clk_i), .rst_b_i(rst_b_i),
	.bus_reference_clock_o(bus_reference_clock_o), .cs_n_o(cs_n_o),
	.rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .addr_o(addr_o), .data_oe_o(data_oe_o)
);

/* File: testbench.sv */
// Self-checking bench for the ready/wait bus engine
`timescale 1ns/1ps
module testbench;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0000_0000, s_axi_rdata_o;
	logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic s_axi_rvalid_o, bus_reference_clock_o, cs_n_o, rd_n_o, wr_n_o;
	logic data_oe_o, ready_i, strb, p_pol = 1'b1;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic [23:0] addr_o, addr_seen = 24'h00_0000;
	logic [15:0] data_o, data_i, p_val = 16'h0000, wr_seen = 16'h0000;
	logic [7:0] p_delay = 8'h00, cs_cnt = 8'h00, st_cnt = 8'h00;
	logic [7:0] cs_len = 8'h00, st_len = 8'h00, st_at = 8'h00;
	int fail_count = 0, num_checks = 0, cyc = 0;
	always #10 clk_i = ~clk_i;
	assign strb = !(rd_n_o && wr_n_o);
	ebw_top #(.TCS_DIV(2)) u_dut (
		.clk_i, .rst_b_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
		.s_axi_wdata_i, .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
		.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
		.s_axi_rvalid_o, .s_axi_rready_i, .bus_reference_clock_o, .cs_n_o,
		.rd_n_o, .wr_n_o, .addr_o, .data_o, .data_oe_o, .data_i, .ready_i
	);
	ebw_partner u_mem (
		.clk_i, .rst_b_i, .cs_n_i(cs_n_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
		.delay_i(p_delay), .pol_i(p_pol), .rdval_i(p_val), .ready_o(ready_i),
		.data_o(data_i)
	);
	// Pin timing measured in system clocks
	always @(posedge clk_i) begin
		cs_cnt <= cs_n_o ? 8'h00 : cs_cnt + 8'h01;
		if (!cs_n_o) cs_len <= cs_cnt + 8'h01;
		st_cnt <= strb ? st_cnt + 8'h01 : 8'h00;
		if (strb) st_len <= st_cnt + 8'h01;
		if (strb && st_cnt == 8'h00) st_at <= cs_cnt;
		if (!wr_n_o && data_oe_o) wr_seen <= data_o;
		if (!cs_n_o) addr_seen <= addr_o;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		while (!done) begin
			@(posedge clk_i);
			if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
			if (s_axi_bvalid_o) begin
				r = s_axi_bresp_o;
				s_axi_bready_i <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		while (!done) begin
			@(posedge clk_i);
			if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
			if (s_axi_rvalid_o) begin
				d = s_axi_rdata_o;
				r = s_axi_rresp_o;
				s_axi_rready_i <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	// Starts a bus cycle and waits until it is over
	task automatic run_cycle(input logic [31:0] cmd, input logic twice,
		output logic [31:0] st);
		logic [1:0] r;
		int n;
		axi_wr(ebw_pkg::OFS_CMD, cmd, r);
		n = 0;
		while (cs_n_o !== 1'b0 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		if (twice) begin
			axi_wr(ebw_pkg::OFS_CMD, cmd, r);
			check("busy go", {30'h0, r}, {30'h0, ebw_pkg::RESP_SLVERR});
		end
		n = 0;
		st = 32'h0000_0001;
		while (st[0] !== 1'b0 && n < 100) begin
			axi_rd(ebw_pkg::OFS_STAT, st, r);
			n++;
		end
		check("busy end", {31'h0, st[0]}, 32'h0000_0000);
	endtask
	task automatic t_reset();
		logic [31:0] rd;
		logic [1:0] r;
		check("cs idle", {31'h0, cs_n_o}, 32'h0000_0001);
		axi_rd(ebw_pkg::OFS_CTRL, rd, r);
		check("ctrl", rd, ebw_pkg::CTRL_RST);
		axi_rd(ebw_pkg::OFS_PHASE, rd, r);
		check("phase", rd, ebw_pkg::PHASE_RST);
		axi_rd(8'h1C, rd, r);
		check("gap resp", {30'h0, r}, {30'h0, ebw_pkg::RESP_SLVERR});
		check("gap data", rd, 32'h0000_0000);
		$display("t_reset done");
	endtask
	// Sync, inverted, async and disabled ready against late answers
	task automatic t_ready();
		logic [2:0] ctl [6] = '{3'h3, 3'h3, 3'h1, 3'h7, 3'h7, 3'h2};
		logic [7:0] dly [6] = '{8'h00, 8'h06, 8'h06, 8'h00, 8'h06, 8'h06};
		logic [7:0] wt [6] = '{8'h00, 8'h03, 8'h03, 8'h01, 8'h04, 8'h00};
		logic [31:0] st, rd;
		logic [1:0] r;
		for (int i = 0; i < 6; i++) begin
			axi_wr(ebw_pkg::OFS_CTRL, {29'h0, ctl[i]}, r);
			@(posedge clk_i);
			p_delay <= dly[i];
			p_pol <= ctl[i][1];
			p_val <= 16'hC3A0 + 16'(i);
			run_cycle(32'h0000_0001, 1'b0, st);
			axi_rd(ebw_pkg::OFS_RDATA, rd, r);
			check("waits", {24'h0, st[15:8]}, {24'h0, wt[i]});
			check("strobe", {24'h0, st_len}, {23'h0, wt[i], 1'b0} + 2);
			check("rdata", rd, {16'h0, 16'hC3A0 + 16'(i)});
		end
		$display("t_ready done");
	endtask
	task automatic t_write();
		logic [31:0] st;
		logic [1:0] r;
		axi_wr(ebw_pkg::OFS_WDATA, 32'h0000_5AF0, r);
		run_cycle(32'h0000_0003, 1'b0, st);
		check("wdata", {16'h0, wr_seen}, 32'h0000_5AF0);
		check("wstrobe", {24'h0, st_len}, 32'h0000_0002);
		$display("t_write done");
	endtask
	// All phases but data setup set, with and without window change
	task automatic t_phase();
		logic [31:0] st;
		logic [1:0] r;
		axi_wr(ebw_pkg::OFS_PHASE, 32'h0003_0339, r);
		axi_wr(ebw_pkg::OFS_ADDR, 32'h0005_0000, r);
		run_cycle(32'h0000_0001, 1'b1, st);
		check("cs len", {24'h0, cs_len}, 32'h0000_001C);
		check("setup", {24'h0, st_at}, 32'h0000_000E);
		check("access", {24'h0, st_len}, 32'h0000_0008);
		check("addr", {8'h0, addr_seen}, 32'h0005_0000);
		run_cycle(32'h0000_0001, 1'b0, st);
		check("cs len2", {24'h0, cs_len}, 32'h0000_0018);
		check("setup2", {24'h0, st_at}, 32'h0000_000A);
		// Late ready with a four unit access phase
		axi_wr(ebw_pkg::OFS_CTRL, 32'h0000_0003, r);
		@(posedge clk_i);
		p_delay <= 8'h14;
		run_cycle(32'h0000_0001, 1'b0, st);
		check("ready waits", {24'h0, st[15:8]}, 32'h0000_0003);
		check("ready access", {24'h0, st_len}, 32'h0000_000E);
		$display("t_phase done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_reset();
		t_ready();
		t_write();
		t_phase();
		print_verdict();
	end
endmodule
